// >>> rtl/aapl_pkg.sv
// Package: map, fields, codes and carriers of the auxiliary axis position latch
package aapl_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_POS = 8'h0c;
   localparam logic [7:0] OFF_REF = 8'h10;
   localparam logic [7:0] OFF_TS = 8'h14;
   localparam logic [7:0] OFF_CNT = 8'h18;
   localparam logic [7:0] OFF_RES = 8'h1c;
   // ----------------------------------------------------------------
   // Control fields, command bits, status bits
   // ----------------------------------------------------------------
   localparam int CTRL_TSEN = 0;
   localparam int CTRL_EDGE = 1;
   localparam int CTRL_SRC = 4;
   localparam int CTRL_CFG = 8;
   localparam int CMD_READ = 0;
   localparam int CMD_CLRCNT = 1;
   localparam int CMD_ACKSIG = 2;
   localparam int CMD_ACKTRG = 3;
   localparam int CMD_CLRREF = 4;
   localparam int CMD_REFBEG = 5;
   localparam int CMD_REFEND = 6;
   localparam int CMD_SW = 8;
   localparam int ST_POSV = 0;
   localparam int ST_REFV = 1;
   localparam int ST_REFACT = 2;
   localparam int ST_AMP = 3;
   localparam int ST_FREQ = 4;
   localparam int ST_LOST = 5;
   localparam int ST_SUPPLY = 6;
   // ----------------------------------------------------------------
   // Encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] REF_EDGE_RISE = 2'h1;
   localparam logic [1:0] REF_EDGE_FALL = 2'h2;
   localparam logic [1:0] REF_EDGE_ANY = 2'h3;
   localparam logic [3:0] SRC_EXT1 = 4'h0;
   localparam logic [3:0] SRC_SW1 = 4'h4;
   localparam logic [3:0] SRC_REF = 4'h8;
   localparam logic [3:0] SRC_REF_CH1 = 4'h9;
   localparam logic [3:0] SRC_IC = 4'ha;
   localparam logic [3:0] SRC_PULSE = 4'hb;
   localparam logic [3:0] SRC_TIMER = 4'hc;
   localparam logic [2:0] RES_OK = 3'h0;
   localparam logic [2:0] RES_LATCH_FAILED = 3'h1;
   localparam logic [2:0] RES_SUPPLY = 3'h2;
   localparam logic [2:0] RES_UNCONFIGURED = 3'h3;
   localparam logic [2:0] RES_BAD_PARAMETER = 3'h4;
   localparam logic [1:0] RST_EDGE = REF_EDGE_RISE;
   localparam logic [3:0] RST_SRC = SRC_SW1;
   localparam int N_PINS = 9;
   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] ext_trig;
      logic amp_fault;
      logic supply_fault;
      logic ref_pulse;
      logic enc_b;
      logic enc_a;
   } aapl_pins_t;
   typedef struct packed {
      logic [3:0] ext_rise;
      logic amp_low;
      logic supply_bad;
      logic ref_rise;
      logic ref_fall;
      logic over_freq;
      logic up;
      logic dn;
   } aapl_ev_t;
endpackage

// >>> rtl/aapl_front.sv
// Pin synchronisers and quadrature / edge decoding for the auxiliary encoder
`timescale 1ns/10ps
`default_nettype none
module aapl_front (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire aapl_pkg::aapl_pins_t pins_in,
   output aapl_pkg::aapl_ev_t ev_out
);
   import aapl_pkg::*;
   logic [N_PINS-1:0] s1;
   logic [N_PINS-1:0] s2;
   logic [N_PINS-1:0] s3;
   aapl_pins_t cur;
   aapl_pins_t prv;
   logic a_chg;
   logic b_chg;
   logic run;

   // ----------------------------------------------------------------
   // Two-stage synchronisers, third stage for edges
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N_PINS; i = i + 1) begin : g_sync
         // No reset: the chain tracks the pins through reset, so no false edge on release
         always_ff @(posedge clk_sys_in) begin
            s1[i] <= pins_in[i];
            s2[i] <= s1[i];
            s3[i] <= s2[i];
         end
      end
   endgenerate

   // Events held off for one cycle out of reset
   always_ff @(posedge clk_sys_in) begin
      run <= rstn_in;
   end

   // Decode from the settled stages only
   assign cur = s2;
   assign prv = s3;
   assign a_chg = cur.enc_a ^ prv.enc_a;
   assign b_chg = cur.enc_b ^ prv.enc_b;
   always_comb begin
      ev_out.ext_rise = cur.ext_trig & ~prv.ext_trig;
      ev_out.amp_low = cur.amp_fault;
      ev_out.supply_bad = cur.supply_fault;
      ev_out.ref_rise = cur.ref_pulse & ~prv.ref_pulse;
      ev_out.ref_fall = ~cur.ref_pulse & prv.ref_pulse;
      // Both tracks moving in one sample means steps were missed
      ev_out.over_freq = a_chg & b_chg;
      ev_out.up = (a_chg ^ b_chg) & (cur.enc_a ^ prv.enc_b);
      ev_out.dn = (a_chg ^ b_chg) & ~(cur.enc_a ^ prv.enc_b);
      if (!run) ev_out = '0;
   end
endmodule // aapl_front
`default_nettype wire

// >>> rtl/aapl_top.sv
// Auxiliary axis position latch: APB registers, trigger select, capture, reference run
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1 - Host issues combined readouts only while polling mode is active.
// R2 - Combined readout latches position and timestamp from one common trigger.
// R3 - Combined readout fires software trigger 1 and forces source to it.
// R4 - Status word flags captured position and saved reference separately valid.
// R5 - Readout reports latch failure, supply fault or unconfigured axis distinctly.
// R6 - Clear-counter command zeroes the position counter.
// R7 - Signal-error acknowledge clears amplitude and over-frequency flags.
// R8 - Trigger-error acknowledge clears the sticky lost-trigger flag.
// R9 - Clear-reference-status command resets the reference-saved bit.
// R10 - Reference-run-active is readable, high while awaiting the reference pulse.
// R11 - A started reference run stores position at the next reference pulse.
// R12 - Stored reference equals the signal-period counter at the mark.
// R13 - Starting a reference run invalidates any stored reference at once.
// R14 - Stopping a run ends capture but keeps stored reference and validity.
// R15 - Timestamp copied into capture only while timestamp enable is set.
// R16 - Timestamp runs on the device-wide period setting.
// R17 - Reference trigger fires on rising, falling or both edges.
// R18 - Host keeps both-edge trigger rate within the maximum trigger rate.
// R19 - Capture source selects external, software, reference, counter or timer triggers.
// R20 - Illegal edge encoding is refused, setting kept, parameter error reported.
module aapl_top (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [aapl_pkg::ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire aapl_pkg::aapl_pins_t pins_in,
   input wire logic ref_gated_ch1_in,
   input wire logic interval_trig_in,
   input wire logic pulse_trig_in,
   input wire logic timer_trig_in,
   input wire logic [31:0] ts_period_in,
   output logic ref_run_active_out
);
   import aapl_pkg::*;
   aapl_ev_t ev;
   logic acc, wr, ctrl_w, cmd_w, hit;
   logic c_read, c_clr, c_acksig, c_acktrg, c_clrref, c_beg, c_end;
   logic [3:0] c_sw, new_src, trig_src, sw_pend;
   logic [1:0] new_edge, ref_edge;
   logic edge_ok, src_ok, ts_en, cfg;
   logic [12:0] trig_vec;
   logic ref_hit, fire, cap_ok, ts_tick;
   logic [31:0] rdata, pos, period, pre, pre_reload, ts;
   logic [31:0] cap_pos, cap_ts, ref_pos;
   logic [15:0] cap_cnt, status;
   logic pos_valid, cap_pend, amp_err, freq_err, lost_trg, ref_valid;
   logic [2:0] result;

   aapl_front u_front (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .pins_in(pins_in),
      .ev_out(ev)
   );

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Transfer completes on the edge that sees pready high
   assign acc = psel_in & penable_in & pready_out;
   assign wr = acc & pwrite_in;
   assign ctrl_w = wr & (paddr_in == OFF_CTRL);
   assign cmd_w = wr & (paddr_in == OFF_CMD);

   // One wait state: pready is set at the end of the first access cycle and is high in the second
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         pready_out <= 1'b0;
         prdata_out <= 32'h0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= psel_in & penable_in & ~pready_out;
         if (psel_in & penable_in & ~pready_out) begin
            prdata_out <= pwrite_in ? 32'h0 : rdata;
            pslverr_out <= ~hit;
         end else begin
            pslverr_out <= 1'b0;
         end
      end
   end

   // Status word: each validity and error bit stands alone
   always_comb begin
      status = 16'h0;
      status[ST_POSV] = pos_valid; // see R4
      status[ST_REFV] = ref_valid; // see R4
      status[ST_REFACT] = ref_run_active_out; // see R10
      status[ST_AMP] = amp_err;
      status[ST_FREQ] = freq_err;
      status[ST_LOST] = lost_trg;
      status[ST_SUPPLY] = ev.supply_bad;
   end

   // Read mux and address decode
   always_comb begin
      hit = 1'b1;
      rdata = 32'h0;
      unique case (paddr_in)
         OFF_CTRL: rdata = {23'h0, cfg, trig_src, 1'b0, ref_edge, ts_en};
         OFF_CMD: rdata = 32'h0;
         OFF_STAT: rdata = {16'h0, status};
         OFF_POS: rdata = cap_pos;
         OFF_REF: rdata = ref_pos;
         OFF_TS: rdata = cap_ts;
         OFF_CNT: rdata = {16'h0, cap_cnt};
         OFF_RES: rdata = {29'h0, result};
         default: hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Commands and settings
   // ----------------------------------------------------------------
   assign c_read = cmd_w & pwdata_in[CMD_READ];
   assign c_clr = cmd_w & pwdata_in[CMD_CLRCNT];
   assign c_acksig = cmd_w & pwdata_in[CMD_ACKSIG];
   assign c_acktrg = cmd_w & pwdata_in[CMD_ACKTRG];
   assign c_clrref = cmd_w & pwdata_in[CMD_CLRREF];
   assign c_beg = cmd_w & pwdata_in[CMD_REFBEG];
   assign c_end = cmd_w & pwdata_in[CMD_REFEND];
   assign c_sw = cmd_w ? pwdata_in[CMD_SW +: 4] : 4'h0;
   assign new_edge = pwdata_in[CTRL_EDGE +: 2];
   assign new_src = pwdata_in[CTRL_SRC +: 4];
   assign edge_ok = (new_edge != 2'h0); // see R20
   assign src_ok = (new_src <= SRC_TIMER);

   // A refused field keeps its old value; the rest still loads
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         ts_en <= 1'b0;
         cfg <= 1'b0;
         ref_edge <= RST_EDGE;
      end else if (ctrl_w) begin
         ts_en <= pwdata_in[CTRL_TSEN];
         cfg <= pwdata_in[CTRL_CFG];
         if (edge_ok) begin
            ref_edge <= new_edge; // see R17
         end
      end
   end

   // Readout steals the source: no restore, software must rewrite it
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         trig_src <= RST_SRC;
      end else if (c_read) begin
         trig_src <= SRC_SW1; // see R3
      end else if (ctrl_w & src_ok) begin
         trig_src <= new_src; // see R19
      end
   end

   // Software trigger pulses, one cycle after the command
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         sw_pend <= 4'h0;
      end else begin
         sw_pend <= c_sw | {3'h0, c_read}; // see R3
      end
   end

   // ----------------------------------------------------------------
   // Trigger selection
   // ----------------------------------------------------------------
   // Edge code bit 0 picks rising, bit 1 falling, both for either
   assign ref_hit = (ref_edge[0] & ev.ref_rise) | (ref_edge[1] & ev.ref_fall); // see R17
   assign trig_vec = {timer_trig_in, pulse_trig_in, interval_trig_in, ref_gated_ch1_in,
                      ref_hit, sw_pend, ev.ext_rise};
   assign fire = trig_vec[trig_src]; // see R19
   assign cap_ok = cfg & ~ev.supply_bad & ~amp_err & ~freq_err;

   // ----------------------------------------------------------------
   // Position counter and timestamp
   // ----------------------------------------------------------------
   // Clear beats a count step in the same cycle
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         pos <= 32'h0;
      end else if (c_clr) begin
         pos <= 32'h0; // see R6
      end else if (ev.up) begin
         pos <= pos + 32'h1;
      end else if (ev.dn) begin
         pos <= pos - 32'h1;
      end
   end
   // Four counts per signal period
   assign period = {{2{pos[31]}}, pos[31:2]};

   // Prescaler runs on the shared period setting, not a local one
   assign pre_reload = (ts_period_in == 32'h0) ? 32'h0 : ts_period_in - 32'h1; // see R16
   assign ts_tick = (pre == 32'h0);
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         pre <= 32'h0;
         ts <= 32'h0;
      end else begin
         pre <= ts_tick ? pre_reload : pre - 32'h1;
         if (ts_tick) begin
            ts <= ts + 32'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Capture
   // ----------------------------------------------------------------
   // Position and timestamp share one trigger edge
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         cap_pos <= 32'h0;
         cap_ts <= 32'h0;
         cap_cnt <= 16'h0;
         pos_valid <= 1'b0;
      end else if (fire) begin
         pos_valid <= cap_ok; // see R4
         if (cap_ok) begin
            cap_pos <= pos; // see R2
            cap_cnt <= cap_cnt + 16'h1;
            if (ts_en) begin
               cap_ts <= ts; // see R15
            end
         end
      end
   end

   // Unread capture; a second trigger on top of it overwrites it and sets lost_trg
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         cap_pend <= 1'b0;
      end else if (fire & cap_ok) begin
         cap_pend <= 1'b1;
      end else if (c_read | (acc & ~pwrite_in & (paddr_in == OFF_POS))) begin
         cap_pend <= 1'b0;
      end
   end

   // Result code: refused setting first, else the last capture outcome
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         result <= RES_OK;
      end else if (ctrl_w & ~(edge_ok & src_ok)) begin
         result <= RES_BAD_PARAMETER; // see R20
      end else if (fire) begin
         if (!cfg) begin
            result <= RES_UNCONFIGURED; // see R5
         end else if (ev.supply_bad) begin
            result <= RES_SUPPLY; // see R5
         end else if (!cap_ok) begin
            result <= RES_LATCH_FAILED; // see R5
         end else begin
            result <= RES_OK;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sticky errors, set wins over acknowledge
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         amp_err <= 1'b0;
         freq_err <= 1'b0;
      end else begin
         amp_err <= ev.amp_low | (amp_err & ~c_acksig); // see R7
         freq_err <= ev.over_freq | (freq_err & ~c_acksig); // see R7
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         lost_trg <= 1'b0;
      end else begin
         lost_trg <= (fire & cap_pend & ~c_read) | (lost_trg & ~c_acktrg); // see R8
      end
   end

   // ----------------------------------------------------------------
   // Reference run
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         ref_run_active_out <= 1'b0;
      end else if (c_beg) begin
         ref_run_active_out <= 1'b1; // see R10
      end else if (c_end | (ref_run_active_out & ref_hit)) begin
         ref_run_active_out <= 1'b0; // see R14
      end
   end

   // Start beats a pulse in the same cycle; a stop leaves these alone
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         ref_valid <= 1'b0;
         ref_pos <= 32'h0;
      end else if (c_beg) begin
         ref_valid <= 1'b0; // see R13
      end else if (ref_run_active_out & ref_hit) begin
         ref_valid <= 1'b1; // see R11
         ref_pos <= period; // see R12
      end else if (c_clrref) begin
         ref_valid <= 1'b0; // see R9
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rstn_in);

   a_readout_source: assert property (c_read |=> trig_src == SRC_SW1 && fire) // see R3
      else $error("readout did not fire software trigger 1");
   a_capture_pair: assert property (fire && cap_ok && ts_en |=> // see R2
      cap_pos == $past(pos) && cap_ts == $past(ts))
      else $error("position and timestamp not captured together");
   a_ts_hold: assert property (fire && !ts_en |=> $stable(cap_ts)) // see R15
      else $error("timestamp copied while disabled");
   a_result_code: assert property (fire && !cfg && !(ctrl_w) |=> // see R5
      result == RES_UNCONFIGURED && !pos_valid)
      else $error("unconfigured axis not reported");
   a_clear_count: assert property (c_clr |=> pos == 32'h0) // see R6
      else $error("counter not cleared");
   a_sig_ack: assert property (c_acksig && !ev.amp_low && !ev.over_freq |=> // see R7
      !amp_err && !freq_err)
      else $error("signal errors not cleared");
   a_lost_ack: assert property (c_acktrg && !fire |=> !lost_trg) // see R8
      else $error("lost trigger flag not cleared");
   a_ref_start: assert property (c_beg |=> !ref_valid && ref_run_active_out) // see R13
      else $error("reference run start did not invalidate");
   a_ref_store: assert property (ref_run_active_out && ref_hit && !c_beg |=> // see R12
      ref_valid && ref_pos == $past(period) && !ref_run_active_out)
      else $error("reference position not stored");
   a_ref_stop: assert property (c_end && !c_beg && !c_clrref |=> // see R14
      !ref_run_active_out && ref_valid == $past(ref_valid))
      else $error("stop changed stored reference");
   a_edge_refuse: assert property (ctrl_w && !edge_ok |=> // see R20
      $stable(ref_edge) && result == RES_BAD_PARAMETER)
      else $error("illegal edge code accepted");

   c_readout_ok: cover property (c_read ##1 (fire && cap_ok) ##1 pos_valid);
   c_ref_run: cover property (c_beg ##[1:50] (ref_valid && !ref_run_active_out));
   c_lost: cover property (fire && cap_pend ##1 lost_trg);
endmodule // aapl_top
`default_nettype wire

// >>> verif/aapl_enc_model.sv
// Behavioural incremental encoder that drives the auxiliary axis pins
`timescale 1ns/10ps
`default_nettype none
module aapl_enc_model (
   input wire logic clk_sys_in,
   output aapl_pkg::aapl_pins_t pins_out
);
   import aapl_pkg::*;
   logic [1:0] ph;
   initial begin
      pins_out = '0;
      ph = 2'h0;
   end
   // Each pin change is held six clocks so the sync chain sees it alone
   task automatic hold;
      repeat (6) @(posedge clk_sys_in);
   endtask
   // Quadrature steps, A leading B when counting up
   task automatic move(input int n);
      repeat (n) begin
         ph = ph + 2'h1;
         pins_out.enc_a <= ph[0] ^ ph[1];
         pins_out.enc_b <= ph[1];
         hold();
      end
   endtask
   // Both lines at once: faster than the inputs may follow
   task automatic jump;
      ph = ph + 2'h2;
      pins_out.enc_a <= ph[0] ^ ph[1];
      pins_out.enc_b <= ph[1];
      hold();
   endtask
   // Reference level changes stay spaced, keeping the event rate low
   task automatic ref_set(input logic v);
      pins_out.ref_pulse <= v;
      hold();
   endtask
   task automatic faults(input logic amp, input logic sup);
      pins_out.amp_fault <= amp;
      pins_out.supply_fault <= sup;
      hold();
   endtask
   task automatic ext1;
      pins_out.ext_trig[0] <= 1'b1;
      hold();
      pins_out.ext_trig[0] <= 1'b0;
      hold();
   endtask
endmodule // aapl_enc_model
`default_nettype wire

// >>> verif/test_aux_axis_position_latch.sv
// Self-checking testbench of the auxiliary axis position latch
`timescale 1ns/10ps
`default_nettype none
module test_aux_axis_position_latch;
   import aapl_pkg::*;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic [31:0] m;
      logic e;} aapl_row_t;
   logic clk_sys_in, rstn_in, psel_in, penable_in, pwrite_in;
   logic [7:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, q, ts1;
   logic pready_out, pslverr_out, ref_run_active_out, e;
   aapl_pins_t pins;
   logic [3:0] trg = 4'h0;
   logic [31:0] tsp = 32'h1;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   aapl_row_t rows[] = '{
      '{OFF_CTRL, 0, 0, 32'h42, '1, 0},
      '{OFF_STAT, 0, 0, 0, '1, 0},
      '{OFF_CMD, 0, 0, 0, '1, 0},
      '{8'h20, 1, 32'h5, 0, 0, 1},
      '{8'h20, 0, 0, 0, '1, 1},
      '{OFF_CTRL, 1, 32'h101, 0, 0, 0},
      '{OFF_CTRL, 0, 0, 32'h103, '1, 0},
      '{OFF_RES, 0, 0, 4, '1, 0},
      '{OFF_CTRL, 1, 32'h1c7, 0, 0, 0},
      '{OFF_CMD, 1, 1, 0, 0, 0},
      '{OFF_CTRL, 0, 0, 32'h147, '1, 0},
      '{OFF_STAT, 0, 0, 1, 32'h7f, 0},
      '{OFF_RES, 0, 0, 0, '1, 0},
      '{OFF_POS, 0, 0, 5, '1, 0},
      '{OFF_CNT, 0, 0, 1, 32'hffff, 0},
      '{OFF_STAT, 1, 32'hff, 0, 0, 0},
      '{OFF_STAT, 0, 0, 0, 32'h7e, 0}};
   aapl_top dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .pins_in(pins), .ref_gated_ch1_in(trg[0]),
      .interval_trig_in(trg[1]), .pulse_trig_in(trg[2]), .timer_trig_in(trg[3]),
      .ts_period_in(tsp), .ref_run_active_out(ref_run_active_out));
   aapl_enc_model enc (.clk_sys_in(clk_sys_in), .pins_out(pins));
   // ----------------------------------------------------------------
   // Clock, timeout, closing report
   // ----------------------------------------------------------------
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   // Whole run needs a few hundred clocks; a hang stops here
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Bus cycles and comparisons
   // ----------------------------------------------------------------
   task automatic chk_w(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
   endtask
   // Ready is sampled at the rising edge; that same edge commits the transfer
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         k++;
      end while (pready_out !== 1'b1 && k < 50);
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      if (k >= 50) chk_w(32'h0, 32'h1);
   endtask
   task automatic cmd(input logic [31:0] v);
      apb(OFF_CMD, 1'b1, v);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      apb(a, 1'b0, 32'h0);
      chk_w(q & m, x);
   endtask
   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      {rstn_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
      repeat (16) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      enc.move(5);
      foreach (rows[i]) begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         if (!rows[i].w) chk_w(q & rows[i].m, rows[i].x);
         chk_w({31'h0, e}, {31'h0, rows[i].e});
      end
      $display("table done");
      cmd(32'h2);
      cmd(32'h1);
      rd(OFF_POS, 0, '1);
      apb(OFF_TS, 1'b0, 0);
      ts1 = q;
      chk_w({31'h0, ts1 != 0}, 32'h1);
      apb(OFF_CTRL, 1'b1, 32'h146);
      cmd(32'h1);
      rd(OFF_TS, ts1, '1);
      $display("counter and timestamp done");
      enc.move(8);
      apb(OFF_CTRL, 1'b1, 32'h144);
      cmd(32'h20);
      @(posedge clk_sys_in);
      chk_w({31'h0, ref_run_active_out}, 32'h1);
      enc.ref_set(1'b1);
      rd(OFF_STAT, 32'h4, 32'h6);
      enc.ref_set(1'b0);
      rd(OFF_STAT, 32'h2, 32'h6);
      rd(OFF_REF, 32'h2, '1);
      chk_w({31'h0, ref_run_active_out}, 32'h0);
      cmd(32'h40);
      rd(OFF_STAT, 32'h2, 32'h6);
      apb(OFF_CTRL, 1'b1, 32'h142);
      cmd(32'h20);
      rd(OFF_STAT, 32'h4, 32'h6);
      enc.ref_set(1'b1);
      rd(OFF_STAT, 32'h2, 32'h6);
      enc.ref_set(1'b0);
      cmd(32'h10);
      rd(OFF_STAT, 32'h0, 32'h6);
      $display("reference run done");
      enc.faults(1'b1, 1'b0);
      cmd(32'h1);
      rd(OFF_RES, 32'h1, '1);
      enc.faults(1'b0, 1'b0);
      cmd(32'h4);
      rd(OFF_STAT, 32'h0, 32'h8);
      enc.jump();
      rd(OFF_STAT, 32'h10, 32'h10);
      cmd(32'h4);
      rd(OFF_STAT, 32'h0, 32'h10);
      enc.faults(1'b0, 1'b1);
      cmd(32'h1);
      rd(OFF_RES, 32'h2, '1);
      enc.faults(1'b0, 1'b0);
      apb(OFF_CTRL, 1'b1, 32'h44);
      cmd(32'h1);
      rd(OFF_RES, 32'h3, '1);
      apb(OFF_CTRL, 1'b1, 32'h104);
      rd(OFF_POS, 32'h0, '1);
      enc.ext1();
      enc.ext1();
      rd(OFF_STAT, 32'h20, 32'h20);
      cmd(32'h8);
      rd(OFF_STAT, 32'h0, 32'h20);
      $display("error flags done");
      tsp <= 32'h4;
      apb(OFF_CTRL, 1'b1, 32'h147);
      cmd(32'h1);
      apb(OFF_TS, 1'b0, 32'h0);
      ts1 = q;
      cmd(32'h1);
      rd(OFF_TS, ts1 + 32'h2, '1);
      for (int s = 9; s < 13; s++) begin
         apb(OFF_CTRL, 1'b1, 32'h102 | (s << 4));
         apb(OFF_CNT, 1'b0, 32'h0);
         ts1 = q + 32'h1;
         trg[s - 9] <= 1'b1;
         @(posedge clk_sys_in);
         trg <= 4'h0;
         rd(OFF_CNT, ts1, 32'hffff);
      end
      $display("timestamp period and trigger inputs done");
      rstn_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      rd(OFF_CTRL, 32'h42, '1);
      rd(OFF_STAT, 32'h0, 32'h7f);
      chk_w({31'h0, ref_run_active_out}, 32'h0);
      $display("mid-run reset done");
      complete_run();
   end
endmodule // test_aux_axis_position_latch
`default_nettype wire
